// File: common/gyro_spi_pkg.sv
package gyro_spi_pkg;

   // Word and frame geometry
   localparam int WORD_W     = 16;
   localparam int BYTE_W     = 8;
   localparam int ADDR_W     = 6;
   localparam int CNT_W      = 5;
   localparam int RATE_W     = 14;
   localparam int NARROW_W   = 12;
   localparam int FLAGGED_N  = 5;
   localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
   localparam logic [CNT_W-1:0] CNT_SAT    = 5'h11;

   // Clock
   localparam int CLK_PERIOD_NS = 4;

   // Byte addresses of the output data registers (lower byte address)
   localparam logic [ADDR_W-1:0] ADDR_FLASH_CNT = 6'h00;
   localparam logic [ADDR_W-1:0] ADDR_SUPPLY    = 6'h02;
   localparam logic [ADDR_W-1:0] ADDR_RATE      = 6'h04;
   localparam logic [ADDR_W-1:0] ADDR_AUX       = 6'h0a;
   localparam logic [ADDR_W-1:0] ADDR_TEMP      = 6'h0c;
   localparam logic [ADDR_W-1:0] ADDR_ANGLE     = 6'h0e;

   // Flag indices for the registers that carry flags
   localparam int IDX_SUPPLY = 0;
   localparam int IDX_RATE   = 1;
   localparam int IDX_AUX    = 2;
   localparam int IDX_TEMP   = 3;
   localparam int IDX_ANGLE  = 4;

   // Field positions
   localparam int NEW_DATA_BIT = 15;
   localparam int ERR_BIT      = 14;
   localparam int OP_HI_BIT    = 15;
   localparam int ADDR_HI_BIT  = 13;

   // Opcodes in the two leading bits
   localparam logic [1:0] OP_READ  = 2'b00;
   localparam logic [1:0] OP_WRITE = 2'b10;

   // Reset values
   localparam logic [WORD_W-1:0] WORD_RST  = 16'h0000;
   localparam logic [WORD_W-1:0] RESP_IDLE = 16'h0000;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SHIFT  = 2'b01,
      ST_DECODE = 2'b11
   } state_t;

endpackage

// File: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               meta_q[i] <= RST_VAL[i];
               q[i]      <= RST_VAL[i];
            end else begin
               meta_q[i] <= d[i];
               q[i]      <= meta_q[i];
            end
         end
      end
   endgenerate
endmodule

// File: rtl/out_word_mux.sv
`timescale 1ns/1ps
module out_word_mux
   import gyro_spi_pkg::*;
(
   input  wire logic [gyro_spi_pkg::ADDR_W-1:0]    rd_addr,
   input  wire logic [gyro_spi_pkg::FLAGGED_N-1:0] new_data,
   input  wire logic                               err_flag,
   input  wire logic [gyro_spi_pkg::WORD_W-1:0]    flash_cnt,
   input  wire logic [gyro_spi_pkg::NARROW_W-1:0]  supply,
   input  wire logic [gyro_spi_pkg::RATE_W-1:0]    rate,
   input  wire logic [gyro_spi_pkg::NARROW_W-1:0]  aux,
   input  wire logic [gyro_spi_pkg::NARROW_W-1:0]  temp,
   input  wire logic [gyro_spi_pkg::RATE_W-1:0]    angle,
   output logic      [gyro_spi_pkg::WORD_W-1:0]    word,
   output logic      [gyro_spi_pkg::FLAGGED_N-1:0] read_hit
);
   import gyro_spi_pkg::*;

   logic [ADDR_W-1:0] reg_addr;

   // Either byte address selects the whole word
   assign reg_addr = {rd_addr[ADDR_W-1:1], 1'b0};

   always_comb begin
      word     = RESP_IDLE;
      read_hit = '0;
      case (reg_addr)
         ADDR_FLASH_CNT: word = flash_cnt;
         ADDR_SUPPLY: begin
            word = {new_data[IDX_SUPPLY], err_flag, 2'b00, supply};
            read_hit[IDX_SUPPLY] = 1'b1;
         end
         ADDR_RATE: begin
            word = {new_data[IDX_RATE], err_flag, rate};
            read_hit[IDX_RATE] = 1'b1;
         end
         ADDR_AUX: begin
            word = {new_data[IDX_AUX], err_flag, 2'b00, aux};
            read_hit[IDX_AUX] = 1'b1;
         end
         ADDR_TEMP: begin
            word = {new_data[IDX_TEMP], err_flag, 2'b00, temp};
            read_hit[IDX_TEMP] = 1'b1;
         end
         ADDR_ANGLE: begin
            word = {new_data[IDX_ANGLE], err_flag, angle};
            read_hit[IDX_ANGLE] = 1'b1;
         end
         default: word = RESP_IDLE;
      endcase
   end
endmodule

// File: rtl/gyro_spi_register_port.sv
`timescale 1ns/1ps
module gyro_spi_register_port
   import gyro_spi_pkg::*;
(
   input  wire logic                              CLK,
   input  wire logic                              RSTN,
   input  wire logic                              CS_N,
   input  wire logic                              SCLK,
   input  wire logic                              DIN,
   output logic                                   DOUT,
   output logic                                   DOUT_OE,
   input  wire logic                              SAMPLE_VALID,
   input  wire logic                              ALARM,
   input  wire logic [gyro_spi_pkg::WORD_W-1:0]   FLASH_COUNT,
   input  wire logic [gyro_spi_pkg::NARROW_W-1:0] SUPPLY_SAMPLE,
   input  wire logic [gyro_spi_pkg::RATE_W-1:0]   RATE_SAMPLE,
   input  wire logic [gyro_spi_pkg::NARROW_W-1:0] AUX_SAMPLE,
   input  wire logic [gyro_spi_pkg::NARROW_W-1:0] TEMP_SAMPLE,
   input  wire logic [gyro_spi_pkg::RATE_W-1:0]   ANGLE_SAMPLE,
   output logic                                   WR_STROBE,
   output logic      [gyro_spi_pkg::ADDR_W-1:0]   WR_ADDR,
   output logic      [gyro_spi_pkg::BYTE_W-1:0]   WR_DATA,
   output logic                                   FRAME_ERROR
);
   import gyro_spi_pkg::*;

   logic                 cs_n_s;
   logic                 sclk_s;
   logic                 din_s;
   logic                 cs_n_d_q;
   logic                 sclk_d_q;
   logic                 cs_fall;
   logic                 cs_rise;
   logic                 sclk_rise;
   logic                 sclk_fall;
   state_t               state_q;
   state_t               state_d;
   logic [CNT_W-1:0]     bit_cnt_q;
   logic [WORD_W-1:0]    rx_q;
   logic [WORD_W-1:0]    tx_sh_q;
   logic [WORD_W-1:0]    resp_q;
   logic                 dout_q;
   logic                 oe_q;
   logic                 wr_strobe_q;
   logic [ADDR_W-1:0]    wr_addr_q;
   logic [BYTE_W-1:0]    wr_data_q;
   logic                 frame_err_q;
   logic                 frame_ok;
   logic                 is_read;
   logic                 is_write;
   logic [WORD_W-1:0]    flash_q;
   logic [NARROW_W-1:0]  supply_q;
   logic [RATE_W-1:0]    rate_q;
   logic [NARROW_W-1:0]  aux_q;
   logic [NARROW_W-1:0]  temp_q;
   logic [RATE_W-1:0]    angle_q;
   logic [FLAGGED_N-1:0] nd_q;
   logic [FLAGGED_N-1:0] nd_clr;
   logic [FLAGGED_N-1:0] read_hit;
   logic                 err_q;
   logic [WORD_W-1:0]    rd_word;

   // Pins pass two flops before use
   pin_sync #(
      .W       (3),
      .RST_VAL (3'h6)
   ) u_pin_sync (
      .clk   (CLK),
      .rst_n (RSTN),
      .d     ({CS_N, SCLK, DIN}),
      .q     ({cs_n_s, sclk_s, din_s})
   );

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         cs_n_d_q <= 1'b1;
         sclk_d_q <= 1'b1;
      end else begin
         cs_n_d_q <= cs_n_s;
         sclk_d_q <= sclk_s;
      end
   end

   assign cs_fall   = cs_n_d_q & ~cs_n_s;
   assign cs_rise   = ~cs_n_d_q & cs_n_s;
   assign sclk_rise = ~sclk_d_q & sclk_s;
   assign sclk_fall = sclk_d_q & ~sclk_s;

   // Frame sequencing
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (cs_fall) begin
               state_d = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (cs_rise) begin
               state_d = ST_DECODE;
            end
         end
         ST_DECODE: state_d = ST_IDLE;
         default:   state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Rising serial clock edges count only inside a frame
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         bit_cnt_q <= '0;
      end else if (cs_fall) begin
         bit_cnt_q <= '0;
      end else if (state_q == ST_SHIFT && sclk_rise && bit_cnt_q != CNT_SAT) begin
         bit_cnt_q <= bit_cnt_q + 5'h01;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         rx_q <= WORD_RST;
      end else if (state_q == ST_SHIFT && sclk_rise && bit_cnt_q < FRAME_BITS) begin
         rx_q <= {rx_q[WORD_W-2:0], din_s};
      end
   end

   assign frame_ok = (bit_cnt_q == FRAME_BITS);
   assign is_read  = frame_ok && (rx_q[OP_HI_BIT -: 2] == OP_READ);
   assign is_write = frame_ok && (rx_q[OP_HI_BIT -: 2] == OP_WRITE);

   // Transmit: first bit at select, next bits on falling serial clock
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         dout_q  <= 1'b0;
         tx_sh_q <= WORD_RST;
      end else if (cs_fall) begin
         dout_q  <= resp_q[WORD_W-1];
         tx_sh_q <= {resp_q[WORD_W-2:0], 1'b0};
      end else if (state_q == ST_SHIFT && sclk_fall && bit_cnt_q != '0 &&
                   bit_cnt_q < FRAME_BITS) begin
         dout_q  <= tx_sh_q[WORD_W-1];
         tx_sh_q <= {tx_sh_q[WORD_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= ~cs_n_s;
      end
   end

   assign DOUT    = dout_q;
   assign DOUT_OE = oe_q;

   // Word for the next frame
   out_word_mux u_out_word_mux (
      .rd_addr   (rx_q[ADDR_HI_BIT -: ADDR_W]),
      .new_data  (nd_q),
      .err_flag  (err_q),
      .flash_cnt (flash_q),
      .supply    (supply_q),
      .rate      (rate_q),
      .aux       (aux_q),
      .temp      (temp_q),
      .angle     (angle_q),
      .word      (rd_word),
      .read_hit  (read_hit)
   );

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         resp_q <= RESP_IDLE;
      end else if (state_q == ST_DECODE) begin
         resp_q <= is_read ? rd_word : RESP_IDLE;
      end
   end

   // Single-byte write port
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         wr_strobe_q <= 1'b0;
         wr_addr_q   <= '0;
         wr_data_q   <= '0;
      end else begin
         wr_strobe_q <= (state_q == ST_DECODE) && is_write;
         if (state_q == ST_DECODE && is_write) begin
            wr_addr_q <= rx_q[ADDR_HI_BIT -: ADDR_W];
            wr_data_q <= rx_q[BYTE_W-1:0];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         frame_err_q <= 1'b0;
      end else begin
         frame_err_q <= (state_q == ST_DECODE) && !frame_ok;
      end
   end

   assign WR_STROBE   = wr_strobe_q;
   assign WR_ADDR     = wr_addr_q;
   assign WR_DATA     = wr_data_q;
   assign FRAME_ERROR = frame_err_q;

   // Output data registers, refreshed by the sample engine
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         flash_q  <= WORD_RST;
         supply_q <= '0;
         rate_q   <= '0;
         aux_q    <= '0;
         temp_q   <= '0;
         angle_q  <= '0;
      end else if (SAMPLE_VALID) begin
         flash_q  <= FLASH_COUNT;
         supply_q <= SUPPLY_SAMPLE;
         rate_q   <= RATE_SAMPLE;
         aux_q    <= AUX_SAMPLE;
         temp_q   <= TEMP_SAMPLE;
         angle_q  <= ANGLE_SAMPLE;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         err_q <= 1'b0;
      end else begin
         err_q <= ALARM;
      end
   end

   // New-data flags: fresh sample wins over a read in the same cycle
   assign nd_clr = (state_q == ST_DECODE && is_read) ? read_hit : '0;

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         nd_q <= '0;
      end else begin
         nd_q <= (nd_q & ~nd_clr) | {FLAGGED_N{SAMPLE_VALID}};
      end
   end

   // Checks
   a_idle_hiz:
   assert property (@(posedge CLK) disable iff (!RSTN)
      cs_n_s |=> !DOUT_OE)
      else $error("output enabled while deselected");

   a_oe_selected:
   assert property (@(posedge CLK) disable iff (!RSTN)
      !cs_n_s |=> DOUT_OE)
      else $error("output not enabled while selected");

   a_frame_len_gate:
   assert property (@(posedge CLK) disable iff (!RSTN)
      (state_q == ST_DECODE && bit_cnt_q != FRAME_BITS) |=> (!WR_STROBE && FRAME_ERROR))
      else $error("short or long frame acted on");

   a_write_single:
   assert property (@(posedge CLK) disable iff (!RSTN)
      WR_STROBE |=> !WR_STROBE)
      else $error("write strobe longer than one cycle");

   a_write_fields:
   assert property (@(posedge CLK) disable iff (!RSTN)
      WR_STROBE |-> (WR_ADDR == $past(rx_q[ADDR_HI_BIT -: ADDR_W]) &&
                     WR_DATA == $past(rx_q[BYTE_W-1:0]) &&
                     $past(rx_q[OP_HI_BIT -: 2]) == OP_WRITE))
      else $error("write fields misplaced");

   a_read_no_write:
   assert property (@(posedge CLK) disable iff (!RSTN)
      (state_q == ST_DECODE && is_read) |=> (!WR_STROBE && resp_q == $past(rd_word)))
      else $error("read frame mishandled");

   a_next_frame_msb:
   assert property (@(posedge CLK) disable iff (!RSTN)
      cs_fall |=> (DOUT == $past(resp_q[WORD_W-1])))
      else $error("first bit is not the msb of the reply");

   a_nd_set:
   assert property (@(posedge CLK) disable iff (!RSTN)
      SAMPLE_VALID |=> (nd_q == {FLAGGED_N{1'b1}}))
      else $error("new-data flag not set by sample");

   a_nd_clear:
   assert property (@(posedge CLK) disable iff (!RSTN)
      (state_q == ST_DECODE && is_read && read_hit[IDX_RATE] && !SAMPLE_VALID)
      |=> !nd_q[IDX_RATE])
      else $error("new-data flag not cleared by read");

   a_flag_layout:
   assert property (@(posedge CLK) disable iff (!RSTN)
      (read_hit != '0) |-> (rd_word[ERR_BIT] == err_q))
      else $error("error flag misplaced");

   a_counter_plain:
   assert property (@(posedge CLK) disable iff (!RSTN)
      (rx_q[ADDR_HI_BIT -: ADDR_W-1] == ADDR_FLASH_CNT[ADDR_W-1:1]) |-> (rd_word == flash_q))
      else $error("counter word altered");

   a_narrow_pad:
   assert property (@(posedge CLK) disable iff (!RSTN)
      (read_hit[IDX_AUX] || read_hit[IDX_SUPPLY] || read_hit[IDX_TEMP])
      |-> (rd_word[ADDR_HI_BIT -: 2] == 2'b00))
      else $error("twelve-bit word padding wrong");

   a_rate_field:
   assert property (@(posedge CLK) disable iff (!RSTN)
      read_hit[IDX_RATE] |-> (rd_word[RATE_W-1:0] == rate_q))
      else $error("rate field wrong");

endmodule

// File: dv/spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (
   output logic      CS_N,
   output logic      SCLK,
   output logic      DIN,
   input  wire logic DOUT,
   input  wire logic DOUT_OE
);
   initial begin
      CS_N = 1'b1;
      SCLK = 1'b1;
      DIN  = 1'b0;
   end

   // Mode 3 frame; low_ns sets the pace, nclk other than 16 breaks the frame
   task automatic xfer(input logic [15:0] tx, input int nclk, input int low_ns,
                       output logic [15:0] rx);
      rx   = '0;
      CS_N = 1'b0;
      #(low_ns);
      for (int i = 0; i < nclk; i++) begin
         SCLK = 1'b0;
         DIN  = tx[15 - (i % 16)];
         #(low_ns);
         SCLK = 1'b1;
         rx   = {rx[14:0], DOUT_OE ? DOUT : ~rx[0]};
         #12;
      end
      #20;
      CS_N = 1'b1;
      DIN  = ~DIN;
      #64;
   endtask

   // Clock and data wiggle with the port deselected
   task automatic noise();
      for (int i = 0; i < 16; i++) begin
         SCLK = 1'b0;
         DIN  = ~DIN;
         #16;
         SCLK = 1'b1;
         #16;
      end
   endtask
endmodule

// File: dv/gyro_spi_register_port_bench.sv
`timescale 1ns/1ps
module gyro_spi_register_port_bench;
   import gyro_spi_pkg::*;
   logic                clk;
   logic                rstn;
   logic                cs_n;
   logic                sclk;
   logic                din;
   logic                dout;
   logic                dout_oe;
   logic                sample_valid;
   logic                alarm;
   logic [WORD_W-1:0]   flash_count;
   logic [NARROW_W-1:0] supply_sample;
   logic [RATE_W-1:0]   rate_sample;
   logic [NARROW_W-1:0] aux_sample;
   logic [NARROW_W-1:0] temp_sample;
   logic [RATE_W-1:0]   angle_sample;
   logic                wr_strobe;
   logic [ADDR_W-1:0]   wr_addr;
   logic [BYTE_W-1:0]   wr_data;
   logic                frame_error;
   int                  num_errors;
   int                  total_checks;
   int                  n_wr;
   int                  n_ferr;
   int                  cycles;
   logic [5:0]          addr_tab [6] = '{6'h00, 6'h02, 6'h04, 6'h0a, 6'h0c, 6'h0e};

   gyro_spi_register_port i_dut (
      .CLK(clk), .RSTN(rstn), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
      .DOUT(dout), .DOUT_OE(dout_oe), .SAMPLE_VALID(sample_valid), .ALARM(alarm),
      .FLASH_COUNT(flash_count), .SUPPLY_SAMPLE(supply_sample),
      .RATE_SAMPLE(rate_sample), .AUX_SAMPLE(aux_sample), .TEMP_SAMPLE(temp_sample),
      .ANGLE_SAMPLE(angle_sample), .WR_STROBE(wr_strobe), .WR_ADDR(wr_addr),
      .WR_DATA(wr_data), .FRAME_ERROR(frame_error)
   );

   spi_master_model i_master (
      .CS_N(cs_n), .SCLK(sclk), .DIN(din), .DOUT(dout), .DOUT_OE(dout_oe)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      if (wr_strobe === 1'b1) n_wr++;
      if (frame_error === 1'b1) n_ferr++;
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Read request; low byte is junk the port must ignore
   task automatic rd(input logic [5:0] a, output logic [15:0] rx);
      i_master.xfer({2'b00, a, 8'ha5}, 16, 20, rx);
   endtask

   task automatic load(input logic alm, input logic [13:0] r);
      @(posedge clk);
      #1;
      alarm         = alm;
      flash_count   = 16'hc3a5;
      supply_sample = 12'h9a1;
      rate_sample   = r;
      aux_sample    = 12'hfff;
      temp_sample   = 12'h801;
      angle_sample  = ~r;
      sample_valid  = 1'b1;
      @(posedge clk);
      #1;
      sample_valid = 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic cmp(input int i, input logic nd, input logic [15:0] rx);
      logic [15:0] e;
      case (i)
         0: e = flash_count;
         1: e = {nd, alarm, 2'b00, supply_sample};
         2: e = {nd, alarm, rate_sample};
         3: e = {nd, alarm, 2'b00, aux_sample};
         4: e = {nd, alarm, 2'b00, temp_sample};
         default: e = {nd, alarm, angle_sample};
      endcase
      if (i inside {1, 3, 4}) rx[13:12] = 2'b00;
      check(rx, e);
   endtask

   task automatic t_idle();
      logic [15:0] rx;
      i_master.noise();
      check({14'h0000, dout_oe, wr_strobe}, 16'h0000);
      check(16'(n_wr + n_ferr), 16'h0000);
      rd(6'h04, rx);
      rd(6'h04, rx);
      check(rx, 16'h0000);
      $display("test idle done");
   endtask

   // Every register read twice: flags of the flagged ones set on first, cleared on second
   task automatic t_read_all(input logic alm, input logic [13:0] r);
      logic [15:0] rx;
      load(alm, r);
      rd(addr_tab[0], rx);
      for (int i = 0; i < 6; i++) begin
         rd(addr_tab[i] + 6'h01, rx);
         cmp(i, 1'b1, rx);
         rd(addr_tab[(i + 1) % 6], rx);
         cmp(i, 1'b0, rx);
      end
      $display("test read done");
   endtask

   task automatic t_write();
      logic [15:0] rx;
      int          n;
      n = n_wr;
      i_master.xfer({2'b10, 6'h3e, 8'h5a}, 16, 20, rx);
      check(16'(n_wr - n), 16'h0001);
      check({2'b00, wr_addr, wr_data}, 16'h3e5a);
      i_master.xfer({2'b10, 6'h3f, 8'hc3}, 16, 36, rx);
      check(16'(n_wr - n), 16'h0002);
      check({2'b00, wr_addr, wr_data}, 16'h3fc3);
      i_master.xfer({2'b11, 6'h3e, 8'h77}, 16, 20, rx);
      check(16'(n_wr - n), 16'h0002);
      $display("test write done");
   endtask

   task automatic t_bad_frame();
      logic [15:0] rx;
      int          n;
      int          m;
      n = n_ferr;
      m = n_wr;
      rd(6'h04, rx);
      i_master.xfer({2'b10, 6'h3e, 8'h11}, 15, 20, rx);
      check(16'(n_ferr - n), 16'h0001);
      check(16'(n_wr - m), 16'h0000);
      rd(6'h04, rx);
      check(rx, 16'h0000);
      i_master.xfer({2'b10, 6'h3e, 8'h22}, 17, 20, rx);
      check(16'(n_ferr - n), 16'h0002);
      check(16'(n_wr - m), 16'h0000);
      $display("test bad frame done");
   endtask

   initial begin
      rstn          = 1'b0;
      sample_valid  = 1'b0;
      alarm         = 1'b0;
      flash_count   = '0;
      supply_sample = '0;
      rate_sample   = '0;
      aux_sample    = '0;
      temp_sample   = '0;
      angle_sample  = '0;
      num_errors    = 0;
      total_checks  = 0;
      n_wr          = 0;
      n_ferr        = 0;
      cycles        = 0;
      repeat (8) @(posedge clk);
      #1;
      rstn = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      t_idle();
      t_read_all(1'b1, 14'h2000);
      t_read_all(1'b0, 14'h0000);
      t_write();
      t_bad_frame();
      close_out();
   end
endmodule
